// ### hw/translate_address_result_page.sv
`timescale 1ns/100ps
// Behaviour
// [R01] initiator sends address, later fetches result
// [R02] header with code 40h, descriptors, entries
// [R03] length counts bytes after length field
// [R04] echo supplied format code
// [R05] echo requested translated format code
// [R06] reserved-region flag when any part reserved
// [R07] entries may be omitted if fully reserved
// [R08] spare-sector flag only when known
// [R09] spare-track flag when present or unknown
// [R10] eight-byte entries from byte six
// [R11] one entry per covered address; the store keeps only the first eight entries, later results are dropped
// [R12] bytes-from-index returns start/end pairs
// [R13] decode defined log page codes
// [R14] reserved and vendor log code ranges
// [R15] unsupported format ends with check condition
// [R16] reserved bytes and bits read zero
module translate_address_result_page
  import xlate_page_pkg::*;
(
  input  wire logic                   clk,          // 100 MHz clock
  input  wire logic                   rst,          // synchronous reset, high
  // request captured from the send-diagnostic page
  input  wire logic                   reqValid,     // pulse: new request
  input  wire logic [FMT_W-1:0]       suppliedFmt,  // supplied format code
  input  wire logic [FMT_W-1:0]       xlateFmt,     // requested target format
  input  wire logic                   suppliedOk,   // supplied format supported
  input  wire logic                   xlateOk,      // target format supported
  // translation results, one per cycle after the request
  input  wire logic                   resValid,     // pulse: one address result
  input  wire logic [63:0]            resAddr,      // address or start location
  input  wire logic [63:0]            resEnd,       // end location (bfi only)
  input  wire logic                   resDone,      // pulse: last result given
  input  wire logic                   anyReserved,  // part lies in reserved area
  input  wire logic                   allReserved,  // whole lies in reserved area
  input  wire logic                   spareSecKnown,// known in alternate sector
  input  wire logic                   spareTrkMaybe,// on/unknown alternate track
  // sense answer
  output      logic                   checkCond,    // pulse: check condition
  output      logic [3:0]             senseKey,     // registered sense key
  output      logic [7:0]             senseCode,    // registered additional code
  // result page stream for receive-diagnostic
  input  wire logic                   pageReq,      // pulse: start page read
  output      logic                   pageValid,    // byte valid
  input  wire logic                   pageReady,    // initiator takes byte
  output      logic [7:0]             pageByte,     // page byte
  output      logic                   pageLast,     // last byte of page
  // log page decode
  input  wire logic [7:0]             logCode,      // log page code
  output      xlate_page_pkg::log_page_t logKind    // decoded class
);
  // ************************************************************
  // request capture and entry store
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_COLLECT = 2'b01,
    ST_READY   = 2'b10,
    ST_SEND    = 2'b11
  } state_t;

  state_t                      state_r, state_nxt;
  logic [FMT_W-1:0]            supFmt_r, supFmt_nxt;
  logic [FMT_W-1:0]            trFmt_r, trFmt_nxt;
  logic                        reserved_region_flag_r, reserved_region_flag_nxt;
  logic                        spSec_r, spSec_nxt;
  logic                        spTrk_r, spTrk_nxt;
  // eight stored entries bound the page at seventy bytes; later results are lost
  logic [63:0]                 store_r [MAX_ENTRIES];
  logic [63:0]                 store_nxt [MAX_ENTRIES];
  logic [ENTRY_IDX_W:0]        count_r, count_nxt;
  logic [POS_W-1:0]            pos_r, pos_nxt;
  logic                        chk_r, chk_nxt;
  logic [3:0]                  sk_r, sk_nxt;
  logic [7:0]                  sc_r, sc_nxt;
  logic [POS_W-1:0]            pageLen;
  logic [POS_W-1:0]            lastPos;
  logic [POS_W-1:0]            entOff;
  logic [ENTRY_IDX_W-1:0]      entIdx;
  logic [BYTE_IDX_W-1:0]       byteIdx;
  logic [7:0]                  entByte;
  logic                        isBfi;

  // taken from the captured code; the input field may already carry the next request
  assign isBfi = (trFmt_r == FMT_BFI);

  // length excludes code, reserved byte and the length field itself
  assign pageLen = POS_W'(DESC_BYTES) + POS_W'(count_r) * POS_W'(ENTRY_BYTES); // [R03]
  assign lastPos = pageLen + POS_W'(HDR_BYTES) - 16'h0001;
  assign entOff  = pos_r - POS_W'(FIRST_ENTRY);                                // [R10]
  assign entIdx  = entOff[BYTE_IDX_W +: ENTRY_IDX_W];
  assign byteIdx = entOff[BYTE_IDX_W-1:0];

  // next-state and capture logic
  always_comb begin
    state_nxt = state_r;
    supFmt_nxt = supFmt_r;
    trFmt_nxt = trFmt_r;
    reserved_region_flag_nxt = reserved_region_flag_r;
    spSec_nxt = spSec_r;
    spTrk_nxt = spTrk_r;
    store_nxt = store_r;
    count_nxt = count_r;
    pos_nxt = pos_r;
    chk_nxt = 1'b0;
    sk_nxt = sk_r;
    sc_nxt = sc_r;
    if (reqValid) begin
      // a new request ends any page in flight and clears the entry count; a refused one keeps the old formats and flags
      if (!suppliedOk || !xlateOk) begin
        chk_nxt = 1'b1;                                                // [R15]
        sk_nxt = SENSE_ILLEGAL_REQ;
        sc_nxt = ASC_INVALID_PARAM;
        state_nxt = ST_IDLE;
        count_nxt = '0;
      end else begin
        supFmt_nxt = suppliedFmt;                                      // [R04]
        trFmt_nxt = xlateFmt;                                          // [R05]
        sk_nxt = '0;
        sc_nxt = '0;
        count_nxt = '0;
        reserved_region_flag_nxt = 1'b0;
        spSec_nxt = 1'b0;
        spTrk_nxt = 1'b0;
        state_nxt = ST_COLLECT;
      end
    end else begin
      unique case (state_r)
        ST_IDLE: begin
        end
        ST_COLLECT: begin
          if (resValid) begin
            reserved_region_flag_nxt = reserved_region_flag_r | anyReserved;                         // [R06]
            spSec_nxt = spSec_r | spareSecKnown;                       // [R08]
            spTrk_nxt = spTrk_r | spareTrkMaybe;                       // [R09]
            // fully reserved results are dropped, flag alone reports them
            if (!allReserved) begin                                    // [R07]
              if (trFmt_r == FMT_BFI) begin
                // start then end; a pair that does not fit is dropped whole
                if (count_r <= (ENTRY_IDX_W+1)'(MAX_ENTRIES - 2)) begin // [R12]
                  // adjacent slots, so a start always precedes its end
                  store_nxt[count_r[ENTRY_IDX_W-1:0]] = resAddr;
                  store_nxt[count_r[ENTRY_IDX_W-1:0] + 1'b1] = resEnd;
                  count_nxt = count_r + 2'd2;
                end
              end else if (count_r < (ENTRY_IDX_W+1)'(MAX_ENTRIES)) begin
                store_nxt[count_r[ENTRY_IDX_W-1:0]] = resAddr;         // [R11]
                count_nxt = count_r + 1'b1;
              end
            end
          end
          if (resDone) state_nxt = ST_READY;
        end
        ST_READY: begin
          if (pageReq) begin                                           // [R01]
            pos_nxt = '0;
            state_nxt = ST_SEND;
          end
        end
        ST_SEND: begin
          // a late pageReady only stalls the stream, the byte keeps standing
          if (pageReady) begin
            if (pos_r == lastPos) state_nxt = ST_READY;  // page may be read again
            else pos_nxt = pos_r + 1'b1;
          end
        end
      endcase
    end
  end

  // registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      supFmt_r <= '0;
      trFmt_r <= '0;
      reserved_region_flag_r <= 1'b0;
      spSec_r <= 1'b0;
      spTrk_r <= 1'b0;
      for (int i = 0; i < MAX_ENTRIES; i++) store_r[i] <= '0;
      count_r <= '0;
      pos_r <= '0;
      chk_r <= 1'b0;
      sk_r <= '0;
      sc_r <= '0;
    end else begin
      state_r <= state_nxt;
      supFmt_r <= supFmt_nxt;
      trFmt_r <= trFmt_nxt;
      reserved_region_flag_r <= reserved_region_flag_nxt;
      spSec_r <= spSec_nxt;
      spTrk_r <= spTrk_nxt;
      store_r <= store_nxt;
      count_r <= count_nxt;
      pos_r <= pos_nxt;
      chk_r <= chk_nxt;
      sk_r <= sk_nxt;
      sc_r <= sc_nxt;
    end
  end

  // ************************************************************
  // page byte mux
  // ************************************************************
  entry_byte_sel u_sel (
    .entry   (store_r[entIdx]),
    .byteIdx (byteIdx),
    .fmt     (trFmt_r),
    .byteOut (entByte)
  );

  // header, descriptors, entries; unused positions stay zero
  always_comb begin
    pageByte = 8'h00;                                                  // [R16]
    unique case (pos_r)
      16'h0000: pageByte = PAGE_CODE_XLATE;                            // [R02]
      16'h0002: pageByte = pageLen[15:8];                              // [R03]
      16'h0003: pageByte = pageLen[7:0];
      16'h0004: pageByte = {5'h00, supFmt_r};                          // [R04]
      16'h0005: begin
        pageByte[BIT_RESERVED_REGION_FLAG]     = reserved_region_flag_r;                             // [R06]
        pageByte[BIT_SPARE_SEC] = spSec_r;                             // [R08]
        pageByte[BIT_SPARE_TRK] = spTrk_r;                             // [R09]
        pageByte[FMT_W-1:0]     = trFmt_r;                             // [R05]
      end
      default: if (pos_r >= POS_W'(FIRST_ENTRY)) pageByte = entByte;   // [R10]
    endcase
  end

  // handshake outputs decode the state; sense stays until the next request
  assign pageValid = (state_r == ST_SEND);
  assign pageLast  = pageValid && (pos_r == lastPos);
  assign checkCond = chk_r;
  assign senseKey  = sk_r;
  assign senseCode = sc_r;

  // log codes are decoded in the same cycle, no register in between
  log_page_decode u_log (
    .pageCode (logCode),
    .pageKind (logKind)
  );

  // ************************************************************
  // checks
  // ************************************************************
  // a new request may cut a page short, so the hold check leaves it out
  a_code_first: assert property (@(posedge clk) disable iff (rst) // [R02]
    $rose(pageValid) |-> pageByte == PAGE_CODE_XLATE)
    else $error("page does not open with its code");
  a_len_match: assert property (@(posedge clk) disable iff (rst) // [R03]
    pageLast |-> pos_r == pageLen + 16'h0003)
    else $error("page length mismatch");
  a_bad_fmt: assert property (@(posedge clk) disable iff (rst) // [R15]
    reqValid && !(suppliedOk && xlateOk) |=> checkCond && senseKey == SENSE_ILLEGAL_REQ)
    else $error("unsupported format not refused");
  a_fmt_echo: assert property (@(posedge clk) disable iff (rst) // [R04]
    reqValid && suppliedOk && xlateOk |=> supFmt_r == $past(suppliedFmt))
    else $error("supplied format not echoed");
  a_xfmt_echo: assert property (@(posedge clk) disable iff (rst) // [R05]
    pageValid && pos_r == 16'h0005 |-> pageByte[FMT_W-1:0] == trFmt_r)
    else $error("translated format not echoed");
  a_rsv_zero: assert property (@(posedge clk) disable iff (rst) // [R16]
    pageValid && pos_r == 16'h0001 |-> pageByte == 8'h00)
    else $error("reserved byte not zero");
  a_reserved_region_flag_set: assert property (@(posedge clk) disable iff (rst) // [R06]
    state_r == ST_COLLECT && resValid && anyReserved && !reqValid |=> reserved_region_flag_r)
    else $error("reserved flag not set");
  a_pair_even: assert property (@(posedge clk) disable iff (rst) // [R12]
    state_r == ST_READY && trFmt_r == FMT_BFI |-> !count_r[0])
    else $error("bytes-from-index entries not paired");
  a_lba_pad: assert property (@(posedge clk) disable iff (rst) // [R10]
    pageValid && trFmt_r == FMT_LBA && pos_r >= 16'h0006 && byteIdx >= 3'h4
      |-> pageByte == 8'h00)
    else $error("logical block padding not zero");
  a_log_vendor: assert property (@(posedge clk) // [R14]
    logCode == LOG_VEND_LO |-> logKind == LP_VENDOR)
    else $error("vendor log code misdecoded");
  a_byte_hold: assert property (@(posedge clk) disable iff (rst) // [R02]
    pageValid && !pageReady && !reqValid |=> pageValid && $stable(pageByte))
    else $error("page byte dropped before it was taken");
  a_desc_zero: assert property (@(posedge clk) disable iff (rst) // [R16]
    pageValid && pos_r == 16'h0004 |-> pageByte[7:FMT_W] == '0)
    else $error("reserved bits of byte four not zero");
  a_flag_clear: assert property (@(posedge clk) disable iff (rst) // [R08]
    reqValid && suppliedOk && xlateOk |=> !spSec_r && !spTrk_r && !reserved_region_flag_r)
    else $error("location flags not cleared by new request");
  a_trk_set: assert property (@(posedge clk) disable iff (rst) // [R09]
    state_r == ST_COLLECT && resValid && spareTrkMaybe && !reqValid |=> spTrk_r)
    else $error("spare-track flag not set");
  a_no_page: assert property (@(posedge clk) disable iff (rst) // [R15]
    reqValid && !(suppliedOk && xlateOk) |=> !pageValid)
    else $error("refused request still offers a page");

  // ************************************************************
  // cover points
  // ************************************************************
  c_page_done: cover property (@(posedge clk) pageLast && pageReady);
  c_refused: cover property (@(posedge clk) checkCond);
  c_bfi_pair: cover property (@(posedge clk) state_r == ST_READY && count_r == 4'h2 && isBfi);
  c_all_rsv: cover property (@(posedge clk) state_r == ST_COLLECT && resValid && allReserved);
  c_lba_page: cover property (@(posedge clk) pageLast && trFmt_r == FMT_LBA);
endmodule : translate_address_result_page

// ### hw/xlate_page_pkg.sv
package xlate_page_pkg;
  // ************************************************************
  // page layout
  // ************************************************************
  localparam logic [7:0] PAGE_CODE_XLATE = 8'h40;
  localparam int         HDR_BYTES       = 4;            // code, reserved, length msb/lsb
  localparam int         DESC_BYTES      = 2;            // format echo bytes 4 and 5
  localparam int         ENTRY_BYTES     = 8;            // one translated address
  localparam int         LBA_BYTES       = 4;            // logical block uses first four
  localparam int         FIRST_ENTRY     = 6;
  localparam int         MAX_ENTRIES     = 8;            // capacity of the entry store
  localparam int         ENTRY_IDX_W     = 3;
  localparam int         BYTE_IDX_W      = 3;
  localparam int         POS_W           = 16;
  localparam int         FMT_W           = 3;
  localparam int         BIT_RESERVED_REGION_FLAG       = 7;
  localparam int         BIT_SPARE_SEC   = 6;
  localparam int         BIT_SPARE_TRK   = 5;

  // ************************************************************
  // address format codes
  // ************************************************************
  localparam logic [2:0] FMT_LBA         = 3'h0;
  localparam logic [2:0] FMT_BFI         = 3'h4;         // bytes from index
  localparam logic [2:0] FMT_PHYS        = 3'h5;

  // ************************************************************
  // log page codes
  // ************************************************************
  localparam logic [7:0] LOG_SUPPORTED   = 8'h00;
  localparam logic [7:0] LOG_OVERRUN     = 8'h01;
  localparam logic [7:0] LOG_ERR_WRITE   = 8'h02;
  localparam logic [7:0] LOG_ERR_READ    = 8'h03;
  localparam logic [7:0] LOG_RSVD_A      = 8'h04;
  localparam logic [7:0] LOG_ERR_VERIFY  = 8'h05;
  localparam logic [7:0] LOG_NON_MEDIUM  = 8'h06;
  localparam logic [7:0] LOG_LAST_EVENTS = 8'h07;
  localparam logic [7:0] LOG_RSVD_LO     = 8'h08;
  localparam logic [7:0] LOG_RSVD_HI     = 8'h2f;
  localparam logic [7:0] LOG_VEND_LO     = 8'h30;
  localparam logic [7:0] LOG_VEND_HI     = 8'h3e;
  localparam logic [7:0] LOG_RSVD_TOP    = 8'h3f;

  typedef enum logic [3:0] {
    LP_SUPPORTED  = 4'h0,
    LP_OVERRUN    = 4'h1,
    LP_ERR_WRITE  = 4'h2,
    LP_ERR_READ   = 4'h3,
    LP_ERR_VERIFY = 4'h4,
    LP_NON_MEDIUM = 4'h5,
    LP_LAST_EVENT = 4'h6,
    LP_RESERVED   = 4'h7,
    LP_VENDOR     = 4'h8,
    LP_INVALID    = 4'h9
  } log_page_t;

  // sense answer for a refused request
  localparam logic [3:0] SENSE_ILLEGAL_REQ = 4'h5;
  localparam logic [7:0] ASC_INVALID_PARAM = 8'h26;
endpackage : xlate_page_pkg

// ### hw/log_page_decode.sv
`timescale 1ns/100ps
// ************************************************************
// log page code decoder
// ************************************************************
module log_page_decode
  import xlate_page_pkg::*;
(
  input  wire logic [7:0]             pageCode,   // log page code
  output      xlate_page_pkg::log_page_t pageKind // decoded class
);
  // pure table lookup, no state
  always_comb begin
    pageKind = LP_INVALID;
    if (pageCode == LOG_SUPPORTED) pageKind = LP_SUPPORTED;          // [R13]
    else if (pageCode == LOG_OVERRUN) pageKind = LP_OVERRUN;
    else if (pageCode == LOG_ERR_WRITE) pageKind = LP_ERR_WRITE;
    else if (pageCode == LOG_ERR_READ) pageKind = LP_ERR_READ;
    else if (pageCode == LOG_ERR_VERIFY) pageKind = LP_ERR_VERIFY;
    else if (pageCode == LOG_NON_MEDIUM) pageKind = LP_NON_MEDIUM;
    else if (pageCode == LOG_LAST_EVENTS) pageKind = LP_LAST_EVENT;
    else if (pageCode == LOG_RSVD_A || pageCode == LOG_RSVD_TOP ||
             (pageCode >= LOG_RSVD_LO && pageCode <= LOG_RSVD_HI))
      pageKind = LP_RESERVED;                                          // [R14]
    else if (pageCode >= LOG_VEND_LO && pageCode <= LOG_VEND_HI)
      pageKind = LP_VENDOR;                                            // [R14]
  end
endmodule : log_page_decode

// ### hw/entry_byte_sel.sv
`timescale 1ns/100ps
// ************************************************************
// picks one byte of an eight-byte address entry
// ************************************************************
module entry_byte_sel
  import xlate_page_pkg::*;
(
  input  wire logic [63:0]           entry,     // entry, msb first on the wire
  input  wire logic [BYTE_IDX_W-1:0] byteIdx,   // 0 = first byte sent
  input  wire logic [FMT_W-1:0]      fmt,       // translated format
  output      logic [7:0]            byteOut    // selected byte
);
  // logical block entries carry only four address bytes, rest zero
  always_comb begin
    byteOut = entry[63 - 8*byteIdx -: 8];
    if (fmt == FMT_LBA && byteIdx >= BYTE_IDX_W'(LBA_BYTES))
      byteOut = 8'h00;                                                 // [R10]
  end
endmodule : entry_byte_sel

// ### verification/initiator_model.sv
`timescale 1ns/100ps
// ************************************************************
// initiator side: sends the request, later fetches the page
// ************************************************************
module initiator_model
  import xlate_page_pkg::*;
(
  input  wire logic             clk,         // bench clock
  output      logic             reqValid,    // request pulse
  output      logic [FMT_W-1:0] suppliedFmt, // supplied format
  output      logic [FMT_W-1:0] xlateFmt,    // wanted format
  output      logic             suppliedOk,  // supplied format known
  output      logic             xlateOk,     // wanted format known
  output      logic             pageReq,     // start of page read
  output      logic             pageReady,   // byte accepted
  input  wire logic             pageValid,   // byte offered
  input  wire logic [7:0]       pageByte,    // offered byte
  input  wire logic             pageLast     // final byte
);
  logic [7:0] got[$];   // bytes taken by the last read
  logic       complete; // final byte seen in time

  // idle levels at time zero
  initial begin
    reqValid = 1'b0;
    suppliedFmt = '0;
    xlateFmt = '0;
    suppliedOk = 1'b0;
    xlateOk = 1'b0;
    pageReq = 1'b0;
    pageReady = 1'b0;
  end

  // the address goes out first; the page is only fetched later
  task automatic send_request(input logic [FMT_W-1:0] sf, input logic [FMT_W-1:0] xf,
                              input logic okS, input logic okX);
    @(posedge clk);
    #1;
    reqValid = 1'b1;
    suppliedFmt = sf;
    xlateFmt = xf;
    suppliedOk = okS;
    xlateOk = okX;
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    // stale fields show the inverse so nothing leans on old values
    suppliedFmt = ~sf;
    xlateFmt = ~xf;
    suppliedOk = ~okS;
    xlateOk = ~okX;
  endtask : send_request

  // fetch the page, holding off bytes where the stall mask says so
  task automatic read_page(input logic [31:0] stall);
    int i;
    got.delete();
    complete = 1'b0;
    @(posedge clk);
    #1;
    pageReq = 1'b1;
    @(posedge clk);
    #1;
    pageReq = 1'b0;
    for (i = 0; i < 200 && !complete; i++) begin
      pageReady = ~stall[i % 32];
      #8;
      if (pageValid === 1'b1 && pageReady) begin
        got.push_back(pageByte);
        complete = (pageLast === 1'b1);
      end
      @(posedge clk);
      #1;
    end
    pageReady = 1'b0;
  endtask : read_page
endmodule : initiator_model

// ### verification/translate_address_result_page_test.sv
`timescale 1ns/100ps
// ************************************************************
// self-checking bench for the result page framer
// ************************************************************
module translate_address_result_page_test;
  import xlate_page_pkg::*;
  logic             clk, rst, reqValid, suppliedOk, xlateOk, resValid, resDone;
  logic [FMT_W-1:0] suppliedFmt, xlateFmt;
  logic [63:0]      resAddr, resEnd;
  logic             anyReserved, allReserved, spareSecKnown, spareTrkMaybe;
  logic             checkCond, pageReq, pageValid, pageReady, pageLast;
  logic [3:0]       senseKey;
  logic [7:0]       senseCode, pageByte, logCode;
  log_page_t        logKind;
  int               fails, n_compared, nCheck, seed, s, x;
  logic [63:0]      ent[$];
  logic [7:0]       exp[$];
  logic [2:0]       fmts[3] = '{FMT_LBA, FMT_BFI, FMT_PHYS};

  translate_address_result_page u_translate_address_result_page (
    .clk(clk), .rst(rst), .reqValid(reqValid), .suppliedFmt(suppliedFmt),
    .xlateFmt(xlateFmt), .suppliedOk(suppliedOk), .xlateOk(xlateOk),
    .resValid(resValid), .resAddr(resAddr), .resEnd(resEnd), .resDone(resDone),
    .anyReserved(anyReserved), .allReserved(allReserved),
    .spareSecKnown(spareSecKnown), .spareTrkMaybe(spareTrkMaybe),
    .checkCond(checkCond), .senseKey(senseKey), .senseCode(senseCode),
    .pageReq(pageReq), .pageValid(pageValid), .pageReady(pageReady),
    .pageByte(pageByte), .pageLast(pageLast), .logCode(logCode), .logKind(logKind));

  initiator_model u_initiator_model (
    .clk(clk), .reqValid(reqValid), .suppliedFmt(suppliedFmt), .xlateFmt(xlateFmt),
    .suppliedOk(suppliedOk), .xlateOk(xlateOk), .pageReq(pageReq),
    .pageReady(pageReady), .pageValid(pageValid), .pageByte(pageByte),
    .pageLast(pageLast));

  // ************************************************************
  // clock, check-condition counter, watchdog
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // counted on the falling edge, where the pulse has settled
  always @(negedge clk) begin
    if (checkCond === 1'b1) nCheck++;
  end

  initial begin
    #200000;
    fails++;
    end_of_test();
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", what, want, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  // reference log page classes, written from the code table
  function automatic log_page_t exp_log(input int c);
    if (c >= 8'h40) return LP_INVALID;
    if (c >= 8'h30 && c <= 8'h3e) return LP_VENDOR;
    case (c)
      0: return LP_SUPPORTED;
      1: return LP_OVERRUN;
      2: return LP_ERR_WRITE;
      3: return LP_ERR_READ;
      5: return LP_ERR_VERIFY;
      6: return LP_NON_MEDIUM;
      7: return LP_LAST_EVENT;
      default: return LP_RESERVED;
    endcase
  endfunction : exp_log

  // one accepted request, n results back to back, page read twice
  task automatic run_case(input logic [2:0] sf, input logic [2:0] xf, input int n);
    logic        ra, ss, st;
    logic [31:0] r;
    int          i, k, b, len, c0;
    ent.delete();
    {ra, ss, st} = 3'h0;
    c0 = nCheck;
    u_initiator_model.send_request(sf, xf, 1'b1, 1'b1);
    for (i = 0; i < n; i++) begin
      r = $random(seed);
      resValid = 1'b1;
      resDone = (i == n - 1);
      resAddr = {$random(seed), $random(seed)};
      resEnd = {$random(seed), $random(seed)};
      anyReserved = r[0];
      allReserved = r[0] & r[1] & r[2];
      spareSecKnown = r[3];
      spareTrkMaybe = r[4];
      ra |= r[0];
      ss |= r[3];
      st |= r[4];
      // a wholly reserved result is left out; store holds eight entries
      if (!allReserved && xf == FMT_BFI && ent.size() + 2 <= MAX_ENTRIES) begin
        ent.push_back(resAddr);
        ent.push_back(resEnd);
      end else if (!allReserved && xf != FMT_BFI && ent.size() < MAX_ENTRIES) begin
        ent.push_back(resAddr);
      end
      @(posedge clk);
      #1;
    end
    if (n == 0) begin
      resDone = 1'b1;
      @(posedge clk);
      #1;
    end
    resValid = 1'b0;
    resDone = 1'b0;
    resAddr = ~resAddr;
    resEnd = ~resEnd;
    // expected page, byte by byte
    len = 2 + 8 * ent.size();
    exp = '{8'h40, 8'h00, len[15:8], len[7:0], {5'h00, sf}, {ra, ss, st, 2'h0, xf}};
    foreach (ent[k]) begin
      for (b = 0; b < 8; b++) begin
        exp.push_back((xf == FMT_LBA && b >= 4) ? 8'h00 : ent[k][63 - 8 * b -: 8]);
      end
    end
    check("sense key", senseKey, 4'h0);
    check("sense code", senseCode, 8'h00);
    repeat (2) begin
      u_initiator_model.read_page($random(seed) & 32'h5555_5555);
      check("page size", u_initiator_model.got.size(), exp.size());
      check("page last", u_initiator_model.complete, 1'b1);
      for (i = 0; i < exp.size() && i < u_initiator_model.got.size(); i++) begin
        check("page byte", u_initiator_model.got[i], exp[i]);
      end
    end
    check("check count", nCheck - c0, 0);
  endtask : run_case

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    int i;
    seed = 32'h68d3_3c16;
    rst = 1'b1;
    {resValid, resDone, anyReserved, allReserved, spareSecKnown, spareTrkMaybe} = 6'h00;
    resAddr = '0;
    resEnd = '0;
    logCode = 8'h00;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    // every format pair, entry counts running past the store size
    for (s = 0; s < 3; s++) begin
      for (x = 0; x < 3; x++) begin
        run_case(fmts[s], fmts[x], 3 * s + x + 1);
      end
    end
    run_case(FMT_BFI, FMT_LBA, 0);
    // refused formats: one check pulse, sense held, no page
    for (i = 0; i < 2; i++) begin
      s = nCheck;
      u_initiator_model.send_request(FMT_LBA, FMT_BFI, i == 1, i == 0);
      repeat (3) @(posedge clk);
      #1;
      check("check pulses", nCheck - s, 1);
      check("sense key", senseKey, SENSE_ILLEGAL_REQ);
      check("sense code", senseCode, ASC_INVALID_PARAM);
      u_initiator_model.read_page(32'h0000_0000);
      check("refused page", u_initiator_model.got.size(), 0);
    end
    run_case(FMT_PHYS, FMT_PHYS, 2);
    // every log page code
    for (i = 0; i < 256; i++) begin
      @(posedge clk);
      #1;
      logCode = i[7:0];
      @(negedge clk);
      check("log kind", logKind, exp_log(i));
    end
    end_of_test();
  end
endmodule : translate_address_result_page_test
